/* design/twe_cfg.svh */
// Offsets, lock keys and timing counts for the two-wire memory block
`ifndef TWE_CFG_SVH
`define TWE_CFG_SVH
`define TWE_ADDR_WIDE_WIPER   8'hf8
`define TWE_ADDR_NARROW_WIPER 8'hf9
`define TWE_ADDR_PROTECT_SEL  8'hfa
`define TWE_ADDR_KEY_FIRST    8'hfb
`define TWE_ADDR_KEY_SECOND   8'hfc
`define TWE_ADDR_RSVD_FIRST   8'hfd
`define TWE_KEY_LOCK_FIRST    8'h56
`define TWE_KEY_LOCK_SECOND   8'h25
`define TWE_KEY_UNLOCK_FIRST  8'h67
`define TWE_KEY_UNLOCK_SECOND 8'h36
`define TWE_NARROW_TOP        7'h63
`define TWE_CTRL_CODE         4'ha
`define TWE_BIT_TOP_PAGE      2
`define TWE_BIT_MID_BLOCK     1
`define TWE_BIT_BOT_BLOCK     0
`define TWE_PAGE_BYTES        8
// Self-timed write time in microseconds, and its cycle count at 20 MHz
`define TWE_WRITE_TIME_US     10
`define TWE_MCLK_MHZ          20
`define TWE_WRITE_CYCLES      (`TWE_WRITE_TIME_US * `TWE_MCLK_MHZ)
`endif

/* design/twe_core.sv */
// Two-wire slave front end with 256-byte memory, wiper bytes and write lock
`timescale 1ns/1ns
`default_nettype none
`include "twe_cfg.svh"

module twe_core
(
   // System
   input  wire logic              mclk,
   input  wire logic              rst,
   // Two-wire link (serial clock is the link domain)
   input  wire logic              linkClk,
   input  wire logic              sdaIn,
   output logic                   sdaOut,
   output logic                   sdaOe,
   // Select straps
   input  wire logic              selectPinLow,
   input  wire logic              selectPinMid,
   input  wire logic              selectPinHigh,
   // Wiper settings and status
   output twe_pkg::twe_byte_t     wideWiper,
   output logic [6:0]             narrowWiper,
   output logic                   lockActive,
   output logic                   writeBusy,
   output logic                   standby
);
   import twe_pkg::*;

   // ****************************************************************
   // Start and stop detection
   // ****************************************************************
   // Start sets on the data edge (clock high); cleared by the first rising edge
   logic startSeen_ff;
   logic startClr_ff;
   logic stopTog_ff;

   always_ff @(negedge sdaIn or posedge rst or posedge startClr_ff)
   begin
      if (rst || startClr_ff)
         startSeen_ff <= 1'b0;
      else if (linkClk)
         startSeen_ff <= 1'b1;
   end

   always_ff @(posedge sdaIn or posedge rst)
   begin
      if (rst)
         stopTog_ff <= 1'b0;
      else if (linkClk)
         stopTog_ff <= ~stopTog_ff;
   end

   // ****************************************************************
   // Link-side shifter and state machine (serial clock domain)
   // ****************************************************************
   twe_state_t state_ff;
   logic [3:0] bitCnt_ff;
   twe_byte_t  shift_ff;
   twe_byte_t  txByte_ff;
   logic       ackPhase_ff;
   logic       ackDrive_ff;
   logic       txDrive_ff;
   logic       ackByDev_ff;
   logic [2:0] strapSync1_ff;
   logic [2:0] strapSync2_ff;
   logic       busySync1_ff;
   logic       busySync2_ff;
   // Link-to-core event toggles and held words
   logic       wrTog_ff;
   twe_byte_t  wrAddr_ff;
   twe_byte_t  wrData_ff;
   logic       setTog_ff;
   logic       rdTog_ff;
   twe_byte_t  linkAddr_ff;
   twe_byte_t  rdByte;

   twe_byte_t  rxByte;
   logic       selMatch;
   logic       startNow;

   assign rxByte   = {shift_ff[6:0], sdaIn};
   assign selMatch = rxByte[7:4] == `TWE_CTRL_CODE &&
                     rxByte[3:1] == strapSync2_ff;
   assign startNow = startSeen_ff;

   always_ff @(posedge linkClk or posedge rst)
   begin
      if (rst)
         startClr_ff <= 1'b0;
      else
         startClr_ff <= startSeen_ff;
   end

   // Busy level and straps cross into the link domain through two flops on rising serial edges
   always_ff @(posedge linkClk or posedge rst)
   begin
      if (rst)
      begin
         busySync1_ff  <= 1'b0;
         busySync2_ff  <= 1'b0;
         strapSync1_ff <= 3'h0;
         strapSync2_ff <= 3'h0;
      end
      else
      begin
         busySync1_ff  <= writeBusy;
         busySync2_ff  <= busySync1_ff;
         strapSync1_ff <= {selectPinHigh, selectPinMid, selectPinLow};
         strapSync2_ff <= strapSync1_ff;
      end
   end

   // Falling serial edge: drive acknowledge or next data bit
   always_ff @(negedge linkClk or posedge rst)
   begin
      if (rst)
      begin
         ackDrive_ff <= 1'b0;
         txDrive_ff  <= 1'b0;
      end
      else
      begin
         ackDrive_ff <= ackPhase_ff && ackByDev_ff &&
                        (state_ff == TWE_WADDR || state_ff == TWE_WDATA ||
                         state_ff == TWE_RDATA);
         txDrive_ff  <= state_ff == TWE_RDATA && !ackPhase_ff &&
                        !txByte_ff[3'd7 - bitCnt_ff[2:0]];
      end
   end

   assign sdaOe  = ackDrive_ff || txDrive_ff;
   assign sdaOut = 1'b0;

   // Rising serial edge: sample data bit
   always_ff @(posedge linkClk or posedge rst)
   begin
      if (rst)
      begin
         state_ff    <= TWE_IDLE;
         bitCnt_ff   <= 4'h0;
         shift_ff    <= 8'h00;
         ackPhase_ff <= 1'b0;
         wrTog_ff    <= 1'b0;
         wrAddr_ff   <= 8'h00;
         wrData_ff   <= 8'h00;
         setTog_ff   <= 1'b0;
         rdTog_ff    <= 1'b0;
         ackByDev_ff <= 1'b0;
         linkAddr_ff <= 8'h00;
         txByte_ff   <= 8'h00;
      end
      else if (startNow)
      begin
         state_ff    <= TWE_DADDR;
         bitCnt_ff   <= 4'h1;
         shift_ff    <= {7'h00, sdaIn};
         ackPhase_ff <= 1'b0;
      end
      else if (ackPhase_ff)
      begin
         ackPhase_ff <= 1'b0;
         bitCnt_ff   <= 4'h0;
         if (state_ff == TWE_RDATA && !ackByDev_ff && sdaIn)
            state_ff <= TWE_SKIP;
         else if (state_ff == TWE_RDATA && !ackByDev_ff)
         begin
            txByte_ff   <= rdByte;
            linkAddr_ff <= linkAddr_ff + 8'h01;
            rdTog_ff    <= ~rdTog_ff;
         end
      end
      else if (state_ff != TWE_IDLE && state_ff != TWE_SKIP)
      begin
         shift_ff  <= rxByte;
         bitCnt_ff <= bitCnt_ff + 4'h1;
         if (bitCnt_ff == 4'h7)
         begin
            ackPhase_ff <= 1'b1;
            // Read data bytes are answered by the master, not by us
            ackByDev_ff <= state_ff != TWE_RDATA;
            case (state_ff)
               TWE_DADDR:
               begin
                  if (selMatch && !busySync2_ff)
                  begin
                     if (rxByte[0])
                     begin
                        state_ff    <= TWE_RDATA;
                        txByte_ff   <= rdByte;
                        linkAddr_ff <= linkAddr_ff + 8'h01;
                        rdTog_ff    <= ~rdTog_ff;
                     end
                     else
                        state_ff <= TWE_WADDR;
                  end
                  else
                  begin
                     state_ff    <= TWE_SKIP;
                     ackPhase_ff <= 1'b0;
                  end
               end
               TWE_WADDR:
               begin
                  linkAddr_ff <= rxByte;
                  setTog_ff   <= ~setTog_ff;
                  state_ff    <= TWE_WDATA;
               end
               TWE_WDATA:
               begin
                  wrAddr_ff   <= linkAddr_ff;
                  wrData_ff   <= rxByte;
                  wrTog_ff    <= ~wrTog_ff;
                  linkAddr_ff <= {linkAddr_ff[7:3], linkAddr_ff[2:0] + 3'h1};
               end
               default:
                  state_ff <= state_ff;
            endcase
         end
      end
   end

   // ****************************************************************
   // Core domain: crossings
   // ****************************************************************
   logic [2:0] wrSync_ff;
   logic [2:0] setSync_ff;
   logic [2:0] rdSync_ff;
   logic [2:0] stopSync_ff;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wrSync_ff   <= 3'h0;
         setSync_ff  <= 3'h0;
         rdSync_ff   <= 3'h0;
         stopSync_ff <= 3'h0;
      end
      else
      begin
         wrSync_ff   <= {wrSync_ff[1:0], wrTog_ff};
         setSync_ff  <= {setSync_ff[1:0], setTog_ff};
         rdSync_ff   <= {rdSync_ff[1:0], rdTog_ff};
         stopSync_ff <= {stopSync_ff[1:0], stopTog_ff};
      end
   end

   logic wrEvt;
   logic setEvt;
   logic rdEvt;
   logic stopEvt;
   assign wrEvt   = wrSync_ff[2] ^ wrSync_ff[1];
   assign setEvt  = setSync_ff[2] ^ setSync_ff[1];
   assign rdEvt   = rdSync_ff[2] ^ rdSync_ff[1];
   assign stopEvt = stopSync_ff[2] ^ stopSync_ff[1];

   // ****************************************************************
   // Memory, page buffer and write protection
   // ****************************************************************
   // Write data held in a page buffer until stop commits it
   twe_byte_t  mem_ff [0:255];
   twe_byte_t  pageData_ff [0:`TWE_PAGE_BYTES-1];
   logic [7:0] pageValid_ff;
   logic [4:0] pageBase_ff;
   logic [7:0] busyCnt_ff;
   logic       locked_ff;
   logic       ptrFollow_ff;

   function automatic logic isProtected(input twe_byte_t addr, input twe_byte_t sel,
                                        input logic lk);
      logic top;
      top = addr >= `TWE_ADDR_WIDE_WIPER;
      isProtected = lk && ((top && sel[`TWE_BIT_TOP_PAGE]) ||
                    (!top && addr[7] && sel[`TWE_BIT_MID_BLOCK]) ||
                    (!addr[7] && sel[`TWE_BIT_BOT_BLOCK]));
   endfunction

   // Read path samples memory held stable by the core across the byte
   assign rdByte = mem_ff[linkAddr_ff];

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pageValid_ff <= 8'h00;
         pageBase_ff  <= 5'h00;
         busyCnt_ff   <= 8'h00;
         locked_ff    <= 1'b0;
         ptrFollow_ff <= 1'b0;
         for (int i = 0; i < `TWE_PAGE_BYTES; i++)
            pageData_ff[i] <= 8'h00;
         for (int i = 0; i < 256; i++)
            mem_ff[i] <= 8'h00;
      end
      else
      begin
         if (busyCnt_ff != 8'h00)
            busyCnt_ff <= busyCnt_ff - 8'h01;
         if (setEvt)
            pageValid_ff <= 8'h00;
         if (wrEvt)
         begin
            pageBase_ff <= wrAddr_ff[7:3];
            pageData_ff[wrAddr_ff[2:0]]  <= wrData_ff;
            pageValid_ff[wrAddr_ff[2:0]] <= 1'b1;
         end
         if (stopEvt && pageValid_ff != 8'h00)
         begin
            busyCnt_ff   <= 8'(`TWE_WRITE_CYCLES);
            pageValid_ff <= 8'h00;
            for (int i = 0; i < `TWE_PAGE_BYTES; i++)
            begin
               if (pageValid_ff[i] &&
                   !isProtected({pageBase_ff, 3'(i)}, mem_ff[`TWE_ADDR_PROTECT_SEL], locked_ff))
               begin
                  // Range select frozen while top page is protected
                  if (!({pageBase_ff, 3'(i)} == `TWE_ADDR_PROTECT_SEL &&
                        locked_ff && mem_ff[`TWE_ADDR_PROTECT_SEL][`TWE_BIT_TOP_PAGE]))
                     mem_ff[{pageBase_ff, 3'(i)}] <= pageData_ff[i];
               end
            end
         end
         // Keys are checked against memory after the commit settles
         if (busyCnt_ff == 8'h01)
         begin
            if (mem_ff[`TWE_ADDR_KEY_FIRST] == `TWE_KEY_LOCK_FIRST &&
                mem_ff[`TWE_ADDR_KEY_SECOND] == `TWE_KEY_LOCK_SECOND)
               locked_ff <= 1'b1;
            else if (mem_ff[`TWE_ADDR_KEY_FIRST] == `TWE_KEY_UNLOCK_FIRST &&
                     mem_ff[`TWE_ADDR_KEY_SECOND] == `TWE_KEY_UNLOCK_SECOND)
               locked_ff <= 1'b0;
         end
         if (rdEvt)
            ptrFollow_ff <= 1'b1;
         if (stopEvt)
            ptrFollow_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wideWiper   <= 8'h00;
         narrowWiper <= 7'h00;
      end
      else
      begin
         wideWiper   <= mem_ff[`TWE_ADDR_WIDE_WIPER];
         narrowWiper <= (mem_ff[`TWE_ADDR_NARROW_WIPER][6:0] > `TWE_NARROW_TOP) ?
                        `TWE_NARROW_TOP : mem_ff[`TWE_ADDR_NARROW_WIPER][6:0];
      end
   end

   assign lockActive = locked_ff;
   assign writeBusy  = busyCnt_ff != 8'h00;
   assign standby    = !writeBusy && !ptrFollow_ff && pageValid_ff == 8'h00;

endmodule
`default_nettype wire

/* design/twe_pkg.sv */
// Types for the two-wire memory block
package twe_pkg;
   typedef enum logic [6:0]
   {
      TWE_IDLE  = 7'h01,
      TWE_DADDR = 7'h02,
      TWE_WADDR = 7'h04,
      TWE_WDATA = 7'h08,
      TWE_RDATA = 7'h10,
      TWE_RACK  = 7'h20,
      TWE_SKIP  = 7'h40
   } twe_state_t;
   typedef logic [7:0] twe_byte_t;
endpackage

/* tb/twe_core_assertions.sv */
// Port-level checks on the two-wire memory block
`timescale 1ns/1ns
`default_nettype none
module twe_core_assertions
(
   // System
   input wire logic               mclk,
   input wire logic               rst,
   // Link and straps
   input wire logic               linkClk,
   input wire logic               sdaIn,
   input wire logic               sdaOut,
   input wire logic               sdaOe,
   input wire logic               selectPinLow,
   input wire logic               selectPinMid,
   input wire logic               selectPinHigh,
   // Status
   input wire twe_pkg::twe_byte_t wideWiper,
   input wire logic [6:0]         narrowWiper,
   input wire logic               lockActive,
   input wire logic               writeBusy,
   input wire logic               standby
);
   import twe_pkg::*;
   logic [8:0] busyCnt_ff;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         busyCnt_ff <= 9'h000;
      else
         busyCnt_ff <= writeBusy ? busyCnt_ff + 9'h001 : 9'h000;
   end
   narrow_clamp_a: assert property (narrowWiper <= 7'h63)
      else $error("narrow wiper above its top position");
   wide_commit_a: assert property ($changed(wideWiper) |-> writeBusy || $past(writeBusy))
      else $error("wide wiper moved outside a write cycle");
   narrow_commit_a: assert property ($changed(narrowWiper) |-> writeBusy || $past(writeBusy))
      else $error("narrow wiper moved outside a write cycle");
   lock_commit_a: assert property ($changed(lockActive) |-> writeBusy || $past(writeBusy))
      else $error("lock mode changed outside a write cycle");
   busy_length_a: assert property ($fell(writeBusy) |-> busyCnt_ff inside {[9'h0c3:9'h0cd]})
      else $error("self-timed write length off");
   busy_standby_a: assert property (writeBusy |-> !standby)
      else $error("standby while write runs");
   busy_noack_a: assert property (writeBusy [*4] |-> !sdaOe)
      else $error("acknowledge during self-timed write");
   standby_return_a: assert property ($fell(writeBusy) |-> ##[0:8] standby)
      else $error("no standby after write completion");
   cover property ($rose(writeBusy));
   cover property ($rose(lockActive));
   cover property ($fell(lockActive));
endmodule
bind twe_core twe_core_assertions i_chk (.mclk(mclk), .rst(rst), .linkClk(linkClk),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .selectPinLow(selectPinLow),
   .selectPinMid(selectPinMid), .selectPinHigh(selectPinHigh), .wideWiper(wideWiper),
   .narrowWiper(narrowWiper), .lockActive(lockActive), .writeBusy(writeBusy),
   .standby(standby));
`default_nettype wire

/* tb/twe_link_master.sv */
// Two-wire bus master model; serial clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module twe_link_master
(
   // Serial clock and pulled-up data line
   output logic      linkClk,
   output logic      sdaIn,
   input  wire logic sdaOe
);
   logic mLow;
   always_comb sdaIn = !(mLow || sdaOe);
   initial
   begin
      linkClk = 1'b1;
      mLow = 1'b0;
   end
   // Data moves 4 ns after the clock falls, never while it is high
   task automatic clkBit(input logic drvLow, output logic seen);
      #4 mLow = drvLow;
      #20 linkClk = 1'b1;
      #12 seen = sdaIn;
      #12 linkClk = 1'b0;
   endtask
   task automatic startC();
      #4 mLow = 1'b0;
      #20 linkClk = 1'b1;
      #24 mLow = 1'b1;
      #24 linkClk = 1'b0;
   endtask
   task automatic stopC();
      #4 mLow = 1'b1;
      #20 linkClk = 1'b1;
      #24 mLow = 1'b0;
      #24;
   endtask
   task automatic recover();
      logic s;
      for (int i = 0; i < 9; i++)
         clkBit(1'b0, s);
   endtask
   task automatic txByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clkBit(!b[i], s);
      clkBit(1'b0, s);
      ack = !s;
   endtask
   task automatic rxByte(input logic ackIt, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         clkBit(1'b0, d[i]);
      clkBit(ackIt, s);
   endtask
endmodule
`default_nettype wire

/* tb/two_wire_eeprom_with_lock_tb_top.sv */
// Self-checking bench for the two-wire memory block
`timescale 1ns/1ns
`default_nettype none
`include "twe_cfg.svh"
module two_wire_eeprom_with_lock_tb_top;
   import twe_pkg::*;
   logic       mclk, rst, linkClk, sdaIn, sdaOut, sdaOe, lockActive, writeBusy, standby, ack;
   logic       lockOn;
   twe_byte_t  wideWiper;
   logic [6:0] narrowWiper;
   logic [15:0] rnd;
   logic [2:0] sel;
   logic [7:0] ptr, rd, wq[$], mem[256];
   int         error_cnt, checks, cycles;
   twe_core i_dut (.mclk(mclk), .rst(rst), .linkClk(linkClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .selectPinLow(sel[0]), .selectPinMid(sel[1]), .selectPinHigh(sel[2]),
      .wideWiper(wideWiper), .narrowWiper(narrowWiper), .lockActive(lockActive),
      .writeBusy(writeBusy), .standby(standby));
   twe_link_master i_mst (.linkClk(linkClk), .sdaIn(sdaIn), .sdaOe(sdaOe));
   always #25 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         error_cnt++;
         give_verdict();
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic guarded(input logic [7:0] a);
      logic [7:0] s = mem[`TWE_ADDR_PROTECT_SEL];
      return lockOn && (a >= 8'hf8 ? s[2] : (a >= 8'h80 ? s[1] : s[0]));
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic busyIs(input logic v);
      for (int k = 0; k < 400 && writeBusy !== v; k++)
         @(negedge mclk);
      chk("busy", {7'h00, v}, {7'h00, writeBusy});
   endtask
   // Never aimed at the reserved tail
   task automatic wr(input logic [7:0] a, input int n);
      logic [7:0] pa [8];
      logic [7:0] pd [8];
      i_mst.startC();
      i_mst.txByte({`TWE_CTRL_CODE, sel, 1'b0}, ack);
      chk("addr ack", 8'h01, {7'h00, ack});
      i_mst.txByte(a, ack);
      for (int i = 0; i < n; i++)
      begin
         pa[i] = {a[7:3], a[2:0] + 3'(i)};
         pd[i] = wq.pop_front();
         i_mst.txByte(pd[i], ack);
         chk("data ack", 8'h01, {7'h00, ack});
      end
      i_mst.stopC();
      for (int i = 0; i < n; i++)
         if (!guarded(pa[i]))
            mem[pa[i]] = pd[i];
      if (mem[8'hfb] == `TWE_KEY_LOCK_FIRST && mem[8'hfc] == `TWE_KEY_LOCK_SECOND)
         lockOn = 1'b1;
      if (mem[8'hfb] == `TWE_KEY_UNLOCK_FIRST && mem[8'hfc] == `TWE_KEY_UNLOCK_SECOND)
         lockOn = 1'b0;
      busyIs(1'b1);
      i_mst.startC();
      i_mst.txByte({`TWE_CTRL_CODE, sel, 1'b0}, ack);
      chk("poll ack", 8'h00, {7'h00, ack});
      i_mst.stopC();
      busyIs(1'b0);
      repeat (10) @(negedge mclk);
      chk("standby", 8'h01, {7'h00, standby});
   endtask
   // Fresh reads load the address by a dummy write and a repeated start
   task automatic rdSeq(input logic [7:0] a, input logic fresh, input int n);
      if (fresh)
      begin
         i_mst.startC();
         i_mst.txByte({`TWE_CTRL_CODE, sel, 1'b0}, ack);
         i_mst.txByte(a, ack);
         ptr = a;
      end
      i_mst.startC();
      i_mst.txByte({`TWE_CTRL_CODE, sel, 1'b1}, ack);
      chk("read ack", 8'h01, {7'h00, ack});
      for (int i = 0; i < n; i++)
      begin
         i_mst.rxByte(i < n - 1, rd);
         chk("read data", mem[ptr], rd);
         ptr = ptr + 8'h01;
      end
      i_mst.stopC();
      repeat (6) @(negedge mclk);
      chk("standby", 8'h01, {7'h00, standby});
   endtask
   task automatic give_verdict();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ***********************************
   // Main sequence
   // ***********************************
   initial
   begin
      mclk = 1'b0;
      rst = 1'b1;
      rnd = 16'haa8c;
      sel = rnd[2:0];
      lockOn = 1'b0;
      ptr = 8'h00;
      foreach (mem[i])
         mem[i] = 8'h00;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      chk("standby", 8'h01, {7'h00, standby});
      chk("sda level", 8'h00, {7'h00, sdaOut});
      i_mst.recover();
      i_mst.startC();
      i_mst.txByte({`TWE_CTRL_CODE, ~sel, 1'b0}, ack);
      chk("foreign ack", 8'h00, {7'h00, ack});
      i_mst.stopC();
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         wq.push_back(rnd[7:0]);
      end
      wr(8'h03, 8);
      rdSeq(8'h00, 1'b1, 8);
      rdSeq(8'h00, 1'b0, 1);
      rdSeq(8'hff, 1'b1, 2);
      wq = '{rnd[15:8], rnd[7:0] | 8'hf0};
      wr(8'hf8, 2);
      chk("wide wiper", mem[8'hf8], wideWiper);
      chk("narrow wiper", 8'h63, {1'b0, narrowWiper});
      wq = '{8'h03, `TWE_KEY_LOCK_FIRST, `TWE_KEY_LOCK_SECOND, rnd[7:0] | 8'h01,
         rnd[15:8] | 8'h80, 8'h11, `TWE_KEY_UNLOCK_FIRST, `TWE_KEY_UNLOCK_SECOND};
      wr(8'hfa, 1);
      wr(8'hfb, 2);
      chk("lock", 8'h01, {7'h00, lockActive});
      wr(8'h10, 1);
      wr(8'h90, 1);
      wr(8'hf8, 1);
      rdSeq(8'h10, 1'b1, 1);
      rdSeq(8'h90, 1'b1, 1);
      chk("wide wiper", mem[8'hf8], wideWiper);
      wr(8'hfb, 2);
      chk("lock", 8'h00, {7'h00, lockActive});
      wq = '{8'h04, `TWE_KEY_LOCK_FIRST, `TWE_KEY_LOCK_SECOND, 8'h22, 8'h07};
      wr(8'hfa, 1);
      wr(8'hfb, 2);
      wr(8'hf8, 1);
      wr(8'hfa, 1);
      chk("wide wiper", mem[8'hf8], wideWiper);
      rdSeq(8'hfa, 1'b1, 1);
      give_verdict();
   end
endmodule
`default_nettype wire
